// ==== tb_weather_line_converter.sv ====
`timescale 1ns/100ps
module tb_weather_line_converter;
	import wlc_pkg::*;
	logic        SYS_CLK, RESET, START, INT_PENDING, stall, MEM_ACK, MEM_REQ;
	logic        REFRESH_READY, REFRESH_VALID, BUSY, DONE, INT_EXIT;
	logic [23:0] NEXT_IC, MEM_ADDR, REFRESH_ADDR, STREAM_ADDR, REFRESH_NEXT, SAVED_STATUS;
	logic [31:0] GPR5_IN, GPR6_IN, GPR7_IN, GPR8_IN, GPR9_IN, GPR10_IN, GPR11_IN;
	logic [31:0] HEADER_WORD, SAVED_WORD0, MAJOR_POS;
	logic [63:0] FPR0_AREA, FPR2_AREA, FPR4_AREA, FPR6_AREA, MEM_RDATA, REFRESH_DATA;
	logic [15:0] COUNT;
	logic [3:0]  delay;
	int          errors, check_count;
	int          cyc = 0;

	wlc_converter uut (.SYS_CLK(SYS_CLK), .RESET(RESET), .START(START), .NEXT_IC(NEXT_IC),
		.GPR5_IN(GPR5_IN), .GPR6_IN(GPR6_IN), .GPR7_IN(GPR7_IN), .GPR8_IN(GPR8_IN),
		.GPR9_IN(GPR9_IN), .GPR10_IN(GPR10_IN), .GPR11_IN(GPR11_IN), .FPR0_AREA(FPR0_AREA),
		.FPR2_AREA(FPR2_AREA), .FPR4_AREA(FPR4_AREA), .FPR6_AREA(FPR6_AREA),
		.INT_PENDING(INT_PENDING), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
		.REFRESH_READY(REFRESH_READY), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
		.REFRESH_VALID(REFRESH_VALID), .REFRESH_ADDR(REFRESH_ADDR), .REFRESH_DATA(REFRESH_DATA),
		.BUSY(BUSY), .DONE(DONE), .INT_EXIT(INT_EXIT), .COUNT(COUNT), .STREAM_ADDR(STREAM_ADDR),
		.REFRESH_NEXT(REFRESH_NEXT), .HEADER_WORD(HEADER_WORD), .SAVED_STATUS(SAVED_STATUS),
		.SAVED_WORD0(SAVED_WORD0), .MAJOR_POS(MAJOR_POS));

	wlc_mem_model mem (.clk(SYS_CLK), .rst(RESET), .delay(delay), .stall(stall),
		.req(MEM_REQ), .addr(MEM_ADDR), .ack(MEM_ACK), .rdata(MEM_RDATA),
		.ready(REFRESH_READY), .valid(REFRESH_VALID), .waddr(REFRESH_ADDR),
		.wdata(REFRESH_DATA));

	function automatic logic [31:0] pt(input int x, input int y);
		return {1'b0, x[14:0], 1'b0, y[14:0]};
	endfunction
	function automatic logic [63:0] hdr(input logic [7:0] c, input logic [7:0] s);
		return {1'b1, 7'h00, c, 16'h0000, s, 24'h00_0000};
	endfunction
	function automatic logic [63:0] exp_out(input logic [15:0] h, input logic t,
		input logic [9:0] mx, input logic [9:0] my, input logic [9:0] qx, input logic [9:0] qy);
		logic c0;
		c0 = (h[7:0] != 8'h00);
		return {FMT_CONST, qy < my, qx < mx, c0, c0 & ~t, h, mx, my, qx - mx, qy - my};
	endfunction

	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wrap_up;
		if (errors == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic run(input logic [15:0] n, input logic ip, input logic [23:0] sa,
		input logic [23:0] ra, input logic [31:0] hw);
		int k;
		k = 0;
		mem.oa.delete();
		mem.od.delete();
		@(posedge SYS_CLK);
		START <= 1'b1;
		INT_PENDING <= ip;
		GPR10_IN <= {16'h0000, n};
		GPR9_IN <= {8'h00, sa};
		GPR5_IN <= {8'h00, ra};
		GPR8_IN <= hw;
		@(posedge SYS_CLK);
		START <= 1'b0;
		@(negedge SYS_CLK);
		while (DONE !== 1'b1 && INT_EXIT !== 1'b1 && k < 3000) begin
			@(negedge SYS_CLK);
			k++;
		end
		// the last output still sits in the output stage when the run ends
		repeat (8) @(negedge SYS_CLK);
		chk("finished", 1, k < 3000);
		chk("busy", 0, BUSY);
	endtask

	task automatic t_zero;
		mem.fetches = 0;
		run(16'h0000, 1'b0, 24'h00_0000, 24'h00_1000, 32'h0000_0000);
		chk("done", 1, DONE);
		chk("fetches", 0, mem.fetches);
		chk("saved_status", NEXT_IC, SAVED_STATUS);
	endtask

	task automatic t_lines;
		mem.m[0] = hdr(8'hA5, 8'h3C);
		for (int i = 1; i < 7; i++) mem.m[i] = {pt(300, 400), pt(250, 500)};
		delay <= 4'h5;
		stall <= 1'b1;
		fork
			begin
				repeat (400) @(negedge SYS_CLK);
				chk("stalled_busy", 1, BUSY);
				chk("stalled_valid", 1, REFRESH_VALID);
				chk("stalled_out", 0, mem.oa.size());
				@(posedge SYS_CLK);
				stall <= 1'b0;
			end
		join_none
		run(16'h0007, 1'b0, 24'h00_0000, 24'h00_1000, 32'h0000_0000);
		delay <= 4'h1;
		chk("header", 32'h0000_A53C, HEADER_WORD);
		chk("out_count", 6, mem.oa.size());
		for (int i = 0; i < 6; i++) begin
			chk("out_addr", 24'h00_1000 + 8 * i, mem.oa[i]);
			chk("out_data", exp_out(16'hA53C, 0, 200, 300, 150, 400), mem.od[i]);
		end
		chk("count", 16'h0001, COUNT);
		chk("stream", 24'h00_0038, STREAM_ADDR);
		chk("refresh_next", 24'h00_1030, REFRESH_NEXT);
		chk("word0", pt(300, 400), SAVED_WORD0);
		chk("major", pt(200, 300), MAJOR_POS);
	endtask

	task automatic t_reject;
		mem.m[0] = hdr(8'h5A, 8'h00);
		mem.m[1] = {pt(710, 710), pt(300, 400)};
		mem.m[2] = {pt(750, 710), pt(300, 400)};
		mem.m[3] = {pt(790, 710), pt(300, 400)};
		mem.m[4] = {pt(50, 50), pt(2000, 50)};
		mem.m[5] = {pt(300, 400), pt(790, 715)};
		mem.m[6] = {pt(300, 400), pt(250, 500)};
		run(16'h0007, 1'b0, 24'h00_0000, 24'h00_2000, 32'h0000_0000);
		chk("out_count", 1, mem.oa.size());
		chk("out_addr", 24'h00_2000, mem.oa[0]);
		chk("out_data", exp_out(16'h5A00, 0, 200, 300, 150, 400), mem.od[0]);
		chk("count", 16'h0001, COUNT);
		chk("stream", 24'h00_0038, STREAM_ADDR);
	endtask

	task automatic t_trunc;
		mem.m[0] = hdr(8'hC3, 8'h7E);
		mem.m[1] = {pt(1500, 500), pt(500, 500)};
		GPR11_IN <= 32'h0000_0003;
		run(16'h0002, 1'b0, 24'h00_0000, 24'h00_3000, 32'h0000_0000);
		GPR11_IN <= 32'h0000_0004;
		chk("out_count", 1, mem.oa.size());
		chk("out_data", exp_out(16'hC37E, 1, 300, 300, 675, 300), mem.od[0]);
		chk("word0", pt(500, 500), SAVED_WORD0);
		chk("major", pt(400, 400), MAJOR_POS);
	endtask

	task automatic t_intr;
		mem.m[0] = hdr(8'h0F, 8'h21);
		mem.m[1] = {pt(300, 400), pt(250, 500)};
		run(16'h0002, 1'b1, 24'h00_0000, 24'h00_4000, 32'h0000_0000);
		chk("int_exit", 1, INT_EXIT);
		chk("done", 0, DONE);
		chk("count", 16'h0001, COUNT);
		chk("stream", 24'h00_0008, STREAM_ADDR);
		chk("out_count", 0, mem.oa.size());
		run(COUNT, 1'b0, STREAM_ADDR, REFRESH_NEXT, HEADER_WORD);
		chk("done", 1, DONE);
		chk("out_addr", 24'h00_4000, mem.oa[0]);
		chk("out_data", exp_out(16'h0F21, 0, 200, 300, 150, 400), mem.od[0]);
	endtask

	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end

	always @(posedge SYS_CLK) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			wrap_up;
		end
	end

	initial begin
		errors = 0;
		check_count = 0;
		RESET = 1'b1;
		START = 1'b0;
		INT_PENDING = 1'b0;
		stall = 1'b0;
		delay = 4'h1;
		NEXT_IC = 24'h00_ABC4;
		GPR5_IN = 32'h0000_0000;
		GPR8_IN = 32'h0000_0000;
		GPR9_IN = 32'h0000_0000;
		GPR10_IN = 32'h0000_0000;
		GPR6_IN = pt(145, 145);
		GPR7_IN = pt(955, 955);
		GPR11_IN = 32'h0000_0004;
		FPR0_AREA = {pt(100, 100), pt(1000, 1000)};
		FPR2_AREA = {pt(700, 700), pt(720, 720)};
		FPR4_AREA = {pt(740, 700), pt(760, 720)};
		FPR6_AREA = {pt(780, 700), pt(800, 720)};
		repeat (8) @(posedge SYS_CLK);
		RESET <= 1'b0;
		t_zero;
		t_lines;
		t_reject;
		t_trunc;
		t_intr;
		wrap_up;
	end
endmodule

// ==== wlc_converter.sv ====
`timescale 1ns/100ps
module wlc_converter (
	input  wire logic                          SYS_CLK,
	input  wire logic                          RESET,
	input  wire logic                          START,
	input  wire logic [wlc_pkg::ADDR_W-1:0]    NEXT_IC,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR5_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR6_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR7_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR8_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR9_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR10_IN,
	input  wire logic [wlc_pkg::WORD_W-1:0]    GPR11_IN,
	input  wire logic [wlc_pkg::DW_W-1:0]      FPR0_AREA,
	input  wire logic [wlc_pkg::DW_W-1:0]      FPR2_AREA,
	input  wire logic [wlc_pkg::DW_W-1:0]      FPR4_AREA,
	input  wire logic [wlc_pkg::DW_W-1:0]      FPR6_AREA,
	input  wire logic                          INT_PENDING,
	input  wire logic                          MEM_ACK,
	input  wire logic [wlc_pkg::DW_W-1:0]      MEM_RDATA,
	input  wire logic                          REFRESH_READY,
	output logic                               MEM_REQ,
	output logic [wlc_pkg::ADDR_W-1:0]         MEM_ADDR,
	output logic                               REFRESH_VALID,
	output logic [wlc_pkg::ADDR_W-1:0]         REFRESH_ADDR,
	output logic [wlc_pkg::DW_W-1:0]           REFRESH_DATA,
	output logic                               BUSY,
	output logic                               DONE,
	output logic                               INT_EXIT,
	output logic [wlc_pkg::CNT_W-1:0]          COUNT,
	output logic [wlc_pkg::ADDR_W-1:0]         STREAM_ADDR,
	output logic [wlc_pkg::ADDR_W-1:0]         REFRESH_NEXT,
	output logic [wlc_pkg::WORD_W-1:0]         HEADER_WORD,
	output logic [wlc_pkg::ADDR_W-1:0]         SAVED_STATUS,
	output logic [wlc_pkg::WORD_W-1:0]         SAVED_WORD0,
	output logic [wlc_pkg::WORD_W-1:0]         MAJOR_POS
);
	import wlc_pkg::*;

	function automatic logic in_area(input logic [31:0] p, input logic [63:0] a);
		logic [14:0] x;
		logic [14:0] y;
		x = p[X_LSB+:CRD_W];
		y = p[Y_LSB+:CRD_W];
		return (x >= a[AREA_X0+:CRD_W]) && (x <= a[AREA_X1+:CRD_W])
			&& (y >= a[AREA_Y0+:CRD_W]) && (y <= a[AREA_Y1+:CRD_W]);
	endfunction

	function automatic logic [31:0] rel(input logic [31:0] p, input logic [63:0] a);
		logic [31:0] r;
		r = '0;
		r[X_LSB+:CRD_W] = p[X_LSB+:CRD_W] - a[AREA_X0+:CRD_W];
		r[Y_LSB+:CRD_W] = p[Y_LSB+:CRD_W] - a[AREA_Y0+:CRD_W];
		return r;
	endfunction

	function automatic logic [31:0] mid(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] r;
		logic [15:0] sx;
		logic [15:0] sy;
		r  = '0;
		sx = {1'b0, a[X_LSB+:CRD_W]} + {1'b0, b[X_LSB+:CRD_W]};
		sy = {1'b0, a[Y_LSB+:CRD_W]} + {1'b0, b[Y_LSB+:CRD_W]};
		r[X_LSB+:CRD_W] = sx[15:1];
		r[Y_LSB+:CRD_W] = sy[15:1];
		return r;
	endfunction

	// value * M * 4^N / 4, kept to the display width
	function automatic logic [9:0] scale(input logic [14:0] v, input logic [7:0] k);
		logic [24:0] p;
		p = {10'h000, v} * {19'h0_0000, k[M_W-1:0]};
		p = p << {k[CONV_N_LSB+:2], 1'b0};
		return p[DISP_W+1:2];
	endfunction

	wlc_state_e      state;
	logic [63:0]     inword;
	logic [31:0]     cur;
	logic [31:0]     hold;
	logic            second_word_pending;
	logic            w1_ok;
	logic            truncated;
	logic [3:0]      tcnt;
	logic [31:0]     sec_rel;
	logic [9:0]      major_x;
	logic [9:0]      major_y;
	logic [9:0]      delta_x;
	logic [9:0]      delta_y;
	logic            sign_x;
	logic            sign_y;
	logic [15:0]     instr_counter;
	logic [63:0]     output_doubleword_reg;
	logic [63:0]     border;
	logic            geo;
	logic            ster;
	logic [31:0]     tmid;
	logic            tgeo;
	logic            tbord;
	logic [9:0]      sx_sc;
	logic [9:0]      sy_sc;
	logic [9:0]      mx_sc;
	logic [9:0]      my_sc;
	logic [10:0]     next_dx;
	logic [10:0]     next_dy;
	logic [15:0]     next_count;
	logic            fifo_in_valid;
	logic            fifo_in_ready;
	logic            fifo_out_valid;
	logic            fifo_out_ready;
	logic [FIFO_W-1:0] fifo_out_data;

	assign border     = {GPR6_IN, GPR7_IN};
	assign geo        = in_area(cur, FPR0_AREA);
	assign ster       = in_area(cur, FPR2_AREA) || in_area(cur, FPR4_AREA)
		|| in_area(cur, FPR6_AREA);
	assign tmid       = mid(cur, hold);
	assign tgeo       = in_area(tmid, FPR0_AREA);
	assign tbord      = in_area(tmid, border);
	assign mx_sc      = scale(MAJOR_POS[X_LSB+:CRD_W], GPR11_IN[7:0]);
	assign my_sc      = scale(MAJOR_POS[Y_LSB+:CRD_W], GPR11_IN[7:0]);
	assign sx_sc      = scale(sec_rel[X_LSB+:CRD_W], GPR11_IN[7:0]);
	assign sy_sc      = scale(sec_rel[Y_LSB+:CRD_W], GPR11_IN[7:0]);
	assign next_dx    = {1'b0, sx_sc} - {1'b0, mx_sc};
	assign next_dy    = {1'b0, sy_sc} - {1'b0, my_sc};
	assign next_count = instr_counter - CNT_ONE;
	assign fifo_in_valid = (state == ST_STORE);

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			state                 <= ST_IDLE;
			inword                <= '0;
			cur                   <= '0;
			hold                  <= '0;
			second_word_pending   <= 1'b0;
			w1_ok                 <= 1'b0;
			truncated             <= 1'b0;
			tcnt                  <= '0;
			sec_rel               <= '0;
			SAVED_WORD0           <= '0;
			MAJOR_POS             <= '0;
			HEADER_WORD           <= '0;
			instr_counter         <= '0;
			COUNT                 <= '0;
			SAVED_STATUS          <= '0;
			STREAM_ADDR           <= '0;
			REFRESH_NEXT          <= '0;
			MEM_REQ               <= 1'b0;
			MEM_ADDR              <= '0;
			BUSY                  <= 1'b0;
			DONE                  <= 1'b0;
			INT_EXIT              <= 1'b0;
		end else begin
			case (state)
				ST_IDLE: begin
					if (START) begin
						SAVED_STATUS  <= NEXT_IC;
						instr_counter <= GPR10_IN[CNT_W-1:0];
						COUNT         <= GPR10_IN[CNT_W-1:0];
						STREAM_ADDR   <= GPR9_IN[ADDR_W-1:0];
						REFRESH_NEXT  <= GPR5_IN[ADDR_W-1:0];
						HEADER_WORD   <= GPR8_IN;
						DONE          <= (GPR10_IN[CNT_W-1:0] == CNT_ZERO);
						INT_EXIT      <= 1'b0;
						BUSY          <= (GPR10_IN[CNT_W-1:0] != CNT_ZERO);
						if (GPR10_IN[CNT_W-1:0] != CNT_ZERO) begin
							state <= ST_FETCH;
						end
					end
				end
				ST_FETCH: begin
					MEM_REQ     <= 1'b1;
					MEM_ADDR    <= STREAM_ADDR;
					STREAM_ADDR <= STREAM_ADDR + DW_STEP;
					state       <= ST_WAIT;
				end
				ST_WAIT: begin
					if (MEM_ACK) begin
						MEM_REQ <= 1'b0;
						inword  <= MEM_RDATA;
						state   <= ST_CLASS;
					end
				end
				ST_CLASS: begin
					w1_ok     <= 1'b0;
					truncated <= 1'b0;
					if (inword[HDR_BIT]) begin
						HEADER_WORD <= {16'h0000, inword[CTRL_LSB+:BYTE_W],
							inword[SYM_LSB+:BYTE_W]};
						state <= ST_CHECK;
					end else begin
						cur                 <= inword[63:32];
						hold                <= inword[31:0];
						second_word_pending <= 1'b1;
						state               <= ST_FILT;
					end
				end
				ST_FILT: begin
					if (second_word_pending) begin
						second_word_pending <= 1'b0;
						cur                 <= hold;
						SAVED_WORD0         <= cur;
						if (geo && ster) begin
							state <= ST_CHECK;
						end else begin
							w1_ok <= geo;
							if (geo) begin
								MAJOR_POS <= rel(cur, FPR0_AREA);
							end
						end
					end else if (!geo) begin
						if (w1_ok) begin
							hold  <= cur;
							cur   <= SAVED_WORD0;
							tcnt  <= TRUNC_MAX;
							state <= ST_TRUNC;
						end else begin
							state <= ST_CHECK;
						end
					end else if (ster) begin
						state <= ST_CHECK;
					end else if (w1_ok) begin
						sec_rel <= rel(cur, FPR0_AREA);
						state   <= ST_SCALE;
					end else begin
						SAVED_WORD0 <= cur;
						MAJOR_POS   <= rel(cur, FPR0_AREA);
						hold        <= SAVED_WORD0;
						tcnt        <= TRUNC_MAX;
						state       <= ST_TRUNC;
					end
				end
				ST_TRUNC: begin
					tcnt <= tcnt - 4'h1;
					if (!tgeo) begin
						hold <= tmid;
					end else if (tbord) begin
						cur <= tmid;
					end
					if (tgeo && !tbord) begin
						sec_rel   <= rel(tmid, FPR0_AREA);
						truncated <= 1'b1;
						state     <= ST_SCALE;
					end else if (tcnt == 4'h1) begin
						state <= ST_CHECK;
					end
				end
				ST_SCALE: begin
					major_x <= mx_sc;
					major_y <= my_sc;
					delta_x <= next_dx[DISP_W-1:0];
					delta_y <= next_dy[DISP_W-1:0];
					sign_x  <= next_dx[DISP_W];
					sign_y  <= next_dy[DISP_W];
					state   <= ST_FMT0;
				end
				ST_FMT0: state <= ST_FMT1;
				ST_FMT1: state <= ST_FMT2;
				ST_FMT2: state <= ST_STORE;
				ST_STORE: begin
					if (fifo_in_ready) begin
						REFRESH_NEXT <= REFRESH_NEXT + DW_STEP;
						state        <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					instr_counter <= next_count;
					if (next_count == CNT_ZERO) begin
						DONE  <= 1'b1;
						BUSY  <= 1'b0;
						state <= ST_IDLE;
					end else begin
						COUNT <= next_count;
						if (INT_PENDING) begin
							INT_EXIT <= 1'b1;
							BUSY     <= 1'b0;
							state    <= ST_IDLE;
						end else begin
							state <= ST_FETCH;
						end
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// three format orders, each filling its own slice of the output word
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			output_doubleword_reg <= '0;
		end else if (state == ST_FMT0) begin
			output_doubleword_reg[OUT_CONST+:4] <= FMT_CONST;
			output_doubleword_reg[FMT0_LSB+:FMT_W] <= {sign_y, sign_x,
				HEADER_WORD[7:0] != SYM_BLANK,
				(HEADER_WORD[7:0] != SYM_BLANK) && !truncated,
				HEADER_WORD[15:0]};
		end else if (state == ST_FMT1) begin
			output_doubleword_reg[FMT1_LSB+:FMT_W] <= {major_x, major_y};
		end else if (state == ST_FMT2) begin
			output_doubleword_reg[FMT2_LSB+:FMT_W] <= {delta_x, delta_y};
		end
	end

	wlc_fifo #(
		.W (FIFO_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk       (SYS_CLK),
		.rst       (RESET),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.in_data   ({REFRESH_NEXT, output_doubleword_reg}),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.out_data  (fifo_out_data)
	);

	assign fifo_out_ready = !REFRESH_VALID || REFRESH_READY;

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			REFRESH_VALID <= 1'b0;
			REFRESH_ADDR  <= '0;
			REFRESH_DATA  <= '0;
		end else if (fifo_out_valid && fifo_out_ready) begin
			REFRESH_VALID <= 1'b1;
			REFRESH_ADDR  <= fifo_out_data[DW_W+:ADDR_W];
			REFRESH_DATA  <= fifo_out_data[DW_W-1:0];
		end else if (REFRESH_READY) begin
			REFRESH_VALID <= 1'b0;
		end
	end

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (RESET);

	sequence s_formats;
		state == ST_FMT0 ##1 state == ST_FMT1 ##1 state == ST_FMT2;
	endsequence

	a_start_park: assert property (state == ST_IDLE && START
		|=> SAVED_STATUS == $past(NEXT_IC)) else $error("ic not parked");
	a_hdr_merge: assert property (state == ST_CLASS && inword[HDR_BIT]
		|=> HEADER_WORD[15:8] == $past(inword[CTRL_LSB+:BYTE_W])
		&& state == ST_CHECK) else $error("header not merged");
	a_data_hold: assert property (state == ST_CLASS && !inword[HDR_BIT]
		|=> second_word_pending && hold == $past(inword[31:0]))
		else $error("second word not held");
	a_w1_fail: assert property (state == ST_FILT && second_word_pending && !geo
		|=> !second_word_pending && cur == $past(hold)
		&& SAVED_WORD0 == $past(cur)) else $error("first word swap");
	a_sterile_rej: assert property (state == ST_FILT && geo && ster
		|=> state == ST_CHECK) else $error("sterile point kept");
	a_both_pass: assert property (state == ST_FILT && !second_word_pending
		&& geo && !ster && w1_ok |=> state == ST_SCALE)
		else $error("truncation not skipped");
	a_format_seq: assert property (state == ST_SCALE
		|=> s_formats ##1 state == ST_STORE) else $error("format order");
	a_count_dec: assert property (state == ST_CHECK
		|=> instr_counter == $past(instr_counter) - CNT_ONE)
		else $error("count not decremented");
	a_int_stop: assert property (state == ST_CHECK && INT_PENDING
		&& instr_counter != CNT_ONE |=> state == ST_IDLE && INT_EXIT)
		else $error("interrupt not honoured");
	a_fetch_step: assert property (state == ST_FETCH
		|=> STREAM_ADDR == $past(STREAM_ADDR) + DW_STEP
		&& MEM_ADDR == $past(STREAM_ADDR)) else $error("stream step");
	a_store_step: assert property (state == ST_STORE && fifo_in_ready
		|=> REFRESH_NEXT == $past(REFRESH_NEXT) + DW_STEP)
		else $error("refresh step");
endmodule

// ==== wlc_fifo.sv ====
`timescale 1ns/100ps
module wlc_fifo #(
	parameter int W = 88,
	parameter int D = 4
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int PW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [PW:0]   count;
	logic          push;
	logic          pop;

	assign in_ready  = (count != (PW+1)'(D));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule

// ==== wlc_mem_model.sv ====
`timescale 1ns/100ps
module wlc_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  delay,
	input  wire logic        stall,
	input  wire logic        req,
	input  wire logic [23:0] addr,
	output logic             ack,
	output logic [63:0]      rdata,
	output logic             ready,
	input  wire logic        valid,
	input  wire logic [23:0] waddr,
	input  wire logic [63:0] wdata
);
	logic [63:0] m [16];
	logic [23:0] oa [$];
	logic [63:0] od [$];
	logic [3:0]  wait_cnt;
	logic        served;
	int          fetches;
	initial begin
		ack = 1'b0;
		ready = 1'b0;
		rdata = 64'h0000_0000_0000_0000;
		fetches = 0;
	end
	// one answer per request; data bus toggles when not answering
	always @(posedge clk) begin
		ack <= 1'b0;
		rdata <= ~rdata;
		if (rst || !req) begin
			wait_cnt <= 4'h0;
			served <= 1'b0;
		end else if (!served) begin
			if (wait_cnt >= delay) begin
				ack <= 1'b1;
				rdata <= m[addr[6:3]];
				served <= 1'b1;
				fetches <= fetches + 1;
			end else begin
				wait_cnt <= wait_cnt + 4'h1;
			end
		end
	end
	// display memory side: logs every accepted output
	always @(posedge clk) begin
		ready <= !stall && !rst;
		if (valid && ready) begin
			oa.push_back(waddr);
			od.push_back(wdata);
		end
	end
endmodule

// ==== wlc_pkg.sv ====
// Notes on behaviour
// - leading bit one means header, zero means data
// - header control and symbol merged into register eight
// - count from register ten, decrement, stop at zero
// - next instruction address parked in saved status
// - interrupts only between whole doublewords, resumable
// - first word first, second held, pending flag set
// - failing first word saved, second word taken next
// - inside point tested against three sterile areas
// - first passing word kept, major position saved
// - reject unless one endpoint passes all filters and no endpoint inside the area is sterile
// - both endpoints pass: skip truncation
// - truncate secondary into the border band
// - truncated endpoint becomes secondary point
// - scale origin-relative coordinates by conversion constant
// - delta is secondary minus major, sign per axis
// - output holds header, major position, signed deltas
// - three format orders build the output doubleword
// - next fetch only when no interrupt pending
// - refresh store address from register five
// - stream address advances one doubleword per fetch
package wlc_pkg;
	localparam int ADDR_W     = 24;
	localparam int WORD_W     = 32;
	localparam int DW_W       = 64;
	localparam int HDR_BIT    = 63;
	localparam int CTRL_LSB   = 48;
	localparam int SYM_LSB    = 24;
	localparam int BYTE_W     = 8;
	localparam int CRD_W      = 15;
	localparam int X_LSB      = 16;
	localparam int Y_LSB      = 0;
	localparam int AREA_X0    = 48;
	localparam int AREA_Y0    = 32;
	localparam int AREA_X1    = 16;
	localparam int AREA_Y1    = 0;
	localparam int CNT_W      = 16;
	localparam int CONV_N_LSB = 6;
	localparam int M_W        = 6;
	localparam int DISP_W     = 10;
	localparam int FMT_W      = 20;
	localparam int OUT_CONST  = 60;
	localparam int FMT0_LSB   = 40;
	localparam int FMT1_LSB   = 20;
	localparam int FMT2_LSB   = 0;
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_W     = ADDR_W + DW_W;
	localparam logic [23:0] DW_STEP    = 24'h00_0008;
	localparam logic [3:0]  TRUNC_MAX  = 4'h9;
	localparam logic [3:0]  FMT_CONST  = 4'h7;
	localparam logic [15:0] CNT_ONE    = 16'h0001;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [7:0]  SYM_BLANK  = 8'h00;

	typedef enum logic [3:0] {
		ST_IDLE  = 4'h0,
		ST_FETCH = 4'h1,
		ST_WAIT  = 4'h3,
		ST_CLASS = 4'h2,
		ST_FILT  = 4'h6,
		ST_TRUNC = 4'h7,
		ST_SCALE = 4'h5,
		ST_FMT0  = 4'h4,
		ST_FMT1  = 4'hC,
		ST_FMT2  = 4'hD,
		ST_STORE = 4'hF,
		ST_CHECK = 4'hE
	} wlc_state_e;
endpackage
